// >>> core/dac_host_pkg.sv
// constants and types shared by the dual converter bus controller
package dac_host_pkg;

	// clock rate and bus timing
	localparam int CLK_MHZ     = 250;
	localparam int T_LOW_NS    = 1300;
	localparam int T_HIGH_NS   = 1200;
	localparam int T_SU_STA_NS = 600;
	localparam int T_HD_STA_NS = 600;
	localparam int T_SU_STO_NS = 600;
	localparam int T_BUF_NS    = 1300;
	localparam int LOW_CYC     = (T_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int HIGH_CYC    = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int SU_STA_CYC  = (T_SU_STA_NS * CLK_MHZ + 999) / 1000;
	localparam int HD_STA_CYC  = (T_HD_STA_NS * CLK_MHZ + 999) / 1000;
	localparam int SU_STO_CYC  = (T_SU_STO_NS * CLK_MHZ + 999) / 1000;
	localparam int BUF_CYC     = (T_BUF_NS * CLK_MHZ + 999) / 1000;
	localparam int LOW_HALF    = LOW_CYC / 2;
	localparam int CNT_W       = 10;

	// register offsets
	localparam logic [7:0] REG_CFG    = 8'h00;
	localparam logic [7:0] REG_CODE   = 8'h04;
	localparam logic [7:0] REG_PD     = 8'h08;
	localparam logic [7:0] REG_GO     = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA  = 8'h14;

	// field positions
	localparam int CFG_LSB_BIT     = 0;
	localparam int CFG_VARIANT_BIT = 1;
	localparam int GO_CHAN_BIT     = 2;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_NACK_BIT     = 1;
	localparam int ST_DONE_BIT     = 2;
	localparam int CODE_W          = 10;

	// slave addresses and command nibbles
	localparam logic [6:0] BASE_ADDR_LO   = 7'h38;
	localparam logic [6:0] BASE_ADDR_HI   = 7'h58;
	localparam logic [3:0] CMD_UPDATE_ALL = 4'hE;
	localparam logic [3:0] CMD_EXTENDED   = 4'hF;
	localparam logic [3:0] EXT_TAIL       = 4'h0;
	localparam logic [3:0] READ_A_TAIL    = 4'h1;
	localparam logic [3:0] READ_B_TAIL    = 4'h2;

	// operations started through the go register
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_POWER = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_NONE  = 2'h3;

	typedef enum logic [3:0] {
		ST_IDLE, ST_START_A, ST_START_B, ST_LOW, ST_HIGH,
		ST_GAP, ST_STOP_A, ST_STOP_B, ST_STOP_C
	} state_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} pin_out_t;

endpackage

// >>> core/sync_2ff.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic [W-1:0] d,
	input  wire logic         clk,
	input  wire logic         rst,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_t;

	sync_t s;
	sync_t next_s;

	// first stage feeds only the second
	always_comb begin
		next_s.first  = d;
		next_s.second = s.first;
	end

	// lines idle high, so reset to ones
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.second;
endmodule

// >>> core/dac_host_ctrl.sv
// two-wire bus master that drives the dual converter
`timescale 1ns/1ps
// Overview of operation
// R1: commands choose input-only or input-and-output loading of a code.
// R2: each code is ten bits, straight binary, 0 to 1023.
// R3: after power-on the device outputs are zero and terminated powered down.
// R4: software must send a power-up command before relying on outputs.
// R5: power-down select 00 up, 01 float, 10 1k, 11 100k.
// R6: device keeps register contents through power-down and restores on wake.
// R7: this master alone makes the clock, never above 400 kHz.
// R8: every word is eight bits followed by one acknowledge pulse.
// R9: data changes only while the clock is low.
// R10: start is data falling, stop is data rising, with clock high.
// R11: device ignores the clock after stop or mismatch until next start.
// R12: at least one clock pulse always separates start from stop.
// R13: writes may chain; a read uses a repeated start before its address.
// R14: device acknowledges address and data by pulling data low.
// R15: on read bytes the master drives the acknowledge slot.
// R16: a missing acknowledge ends the transfer and is reported for retry.
// R17: device drops out as soon as an address bit mismatches.
// R18: address is seven bits then direction bit, 0 write, 1 read.
// R19: address top six bits come from the variant, low bit from a pin.
// R20: write bytes carry command, code, and two pad bits sent as zero.
// R21: device updates registers on the clock fall of the last acknowledge.
// R22: an aborted write changes nothing and must be repeated whole.
// R23: read returns two bytes, the master acknowledging the first.
// R24: extended word sets chosen channels to the chosen power-down mode.
// R25: device ignores general call and ten-bit addressing.
// R26: extended command is command all ones with top code bits zero.
// R27: mismatched device leaves data released until next start.
// R28: device filters start and stop detection from data glitches.
module dac_host_ctrl
	import dac_host_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire bus_req_t req,
	input  wire logic     scl_in,
	input  wire logic     sda_in,
	output logic [31:0]   rdata,
	output pin_out_t      pins
);
	typedef struct packed {
		state_t           st;
		logic [CNT_W-1:0] cnt;
		logic [3:0]       bitn;
		logic [1:0]       byten;
		logic [1:0]       nbytes;
		logic [7:0]       shreg;
		logic             seg_rd;
		logic             reading;
		logic [1:0]       op;
		logic             chan;
		logic             addr_lsb;
		logic             variant;
		logic [13:0]      code_reg;
		logic [3:0]       pd_reg;
		logic             nack;
		logic             done;
		logic [15:0]      rd_word;
		logic [31:0]      rdata;
		pin_out_t         pins;
	} ctl_t;

	ctl_t       s;
	ctl_t       n;
	logic [1:0] pin_s;
	logic       scl_s;
	logic       sda_s;
	logic       ack_end;

	// both pins pass two flops before use
	sync_2ff #(.W(2)) u_sync (
		.d   ({scl_in, sda_in}),
		.clk (clk),
		.rst (rst),
		.q   (pin_s)
	);
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	// byte to send at position idx of the current segment
	function automatic logic [7:0] wr_byte(input ctl_t c,
			input logic [1:0] idx);
		logic [6:0] dev;
		dev = {(c.variant ? BASE_ADDR_HI[6:1] : BASE_ADDR_LO[6:1]),
			c.addr_lsb}; // R19
		wr_byte = 8'h00;
		case (idx)
		2'h0: wr_byte = {dev, c.seg_rd}; // R18
		2'h1: begin
			case (c.op)
			OP_WRITE: wr_byte = {c.code_reg[13:10], c.code_reg[9:6]}; // R1
			OP_POWER: wr_byte = {CMD_EXTENDED, EXT_TAIL}; // R26
			default:  wr_byte = {CMD_EXTENDED,
				(c.chan ? READ_B_TAIL : READ_A_TAIL)};
			endcase
		end
		default: begin
			if (c.op == OP_POWER) begin
				wr_byte = {2'h0, c.pd_reg[3:2], c.pd_reg[1:0], 2'h0}; // R24 R5 R4
			end else begin
				wr_byte = {c.code_reg[5:0], 2'h0}; // R20 R2
			end
		end
		endcase
	endfunction

	// end of a high phase in the acknowledge slot
	assign ack_end = (s.st == ST_HIGH) && (s.bitn == 4'h8) && scl_s
		&& (s.cnt == '0);

	// register access, then the bus sequencer
	always_comb begin
		n = s;
		n.rdata = 32'h0000_0000;
		if (req.wr) begin
			case (req.addr)
			REG_CFG: begin
				n.addr_lsb = req.wdata[CFG_LSB_BIT];
				n.variant  = req.wdata[CFG_VARIANT_BIT];
			end
			REG_CODE: n.code_reg = req.wdata[13:0];
			REG_PD:   n.pd_reg = req.wdata[3:0];
			REG_STATUS: begin
				if (req.wdata[ST_NACK_BIT]) begin
					n.nack = 1'b0;
				end
				if (req.wdata[ST_DONE_BIT]) begin
					n.done = 1'b0;
				end
			end
			default: ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
			REG_CFG:  n.rdata = {30'h0, s.variant, s.addr_lsb};
			REG_CODE: n.rdata = {18'h0, s.code_reg};
			REG_PD:   n.rdata = {28'h0, s.pd_reg};
			REG_STATUS: begin
				n.rdata[ST_BUSY_BIT] = (s.st != ST_IDLE);
				n.rdata[ST_NACK_BIT] = s.nack;
				n.rdata[ST_DONE_BIT] = s.done;
			end
			REG_RDATA: n.rdata = {16'h0, s.rd_word};
			default:   n.rdata = 32'h0000_0000;
			endcase
		end
		if (s.cnt != '0) begin
			n.cnt = s.cnt - 1'b1;
		end
		case (s.st)
		ST_IDLE: begin
			n.pins.scl_oe = 1'b0;
			n.pins.sda_oe = 1'b0;
			if (req.wr && req.addr == REG_GO
					&& req.wdata[1:0] != OP_NONE) begin
				n.op      = req.wdata[1:0];
				n.chan    = req.wdata[GO_CHAN_BIT];
				n.seg_rd  = 1'b0;
				n.reading = 1'b0;
				n.byten   = 2'h0;
				if (req.wdata[1:0] == OP_READ) begin
					n.nbytes = 2'h2;
				end else if (req.wdata[1:0] == OP_WRITE
						&& s.code_reg[13:10] == CMD_UPDATE_ALL) begin
					n.nbytes = 2'h2;
				end else begin
					n.nbytes = 2'h3;
				end
				n.st  = ST_START_A;
				n.cnt = CNT_W'(SU_STA_CYC - 1);
			end
		end
		ST_START_A: begin
			if (s.cnt == '0 && scl_s) begin
				n.pins.sda_oe = 1'b1; // R10
				n.st  = ST_START_B;
				n.cnt = CNT_W'(HD_STA_CYC - 1);
			end
		end
		ST_START_B: begin
			if (s.cnt == '0) begin
				n.pins.scl_oe = 1'b1;
				n.bitn  = 4'h0;
				n.shreg = wr_byte(s, 2'h0); // R12
				n.st    = ST_LOW;
				n.cnt   = CNT_W'(LOW_CYC - 1);
			end
		end
		ST_LOW: begin
			// data moves only in mid low phase
			if (s.cnt == CNT_W'(LOW_HALF)) begin
				if (s.bitn != 4'h8) begin
					n.pins.sda_oe = !s.reading && !s.shreg[7]; // R9
				end else begin
					n.pins.sda_oe = s.reading && (s.byten == 2'h0); // R15 R23
				end
			end
			if (s.cnt == '0) begin
				n.pins.scl_oe = 1'b0;
				n.st  = ST_HIGH;
				n.cnt = CNT_W'(HIGH_CYC - 1);
			end
		end
		ST_HIGH: begin
			if (!scl_s) begin
				n.cnt = s.cnt; // wait for the line to rise
			end else if (s.cnt == '0) begin
				n.pins.scl_oe = 1'b1;
				n.st  = ST_LOW;
				n.cnt = CNT_W'(LOW_CYC - 1);
				n.bitn = 4'h0;
				if (s.bitn != 4'h8) begin
					n.shreg = {s.shreg[6:0], s.reading & sda_s};
					n.bitn  = s.bitn + 4'h1; // R8
				end else if (!s.reading && sda_s) begin
					n.nack = 1'b1; // R16 R22
					n.st   = ST_STOP_A;
				end else if (s.reading) begin
					if (s.byten == 2'h0) begin
						n.rd_word[15:8] = s.shreg; // R23
						n.byten = 2'h1;
					end else begin
						n.rd_word[7:0] = s.shreg;
						n.done = 1'b1;
						n.st   = ST_STOP_A;
					end
				end else if (s.byten + 2'h1 < s.nbytes) begin
					n.byten = s.byten + 2'h1;
					n.shreg = wr_byte(s, s.byten + 2'h1); // R14
				end else if (s.seg_rd) begin
					n.reading = 1'b1;
					n.byten   = 2'h0;
				end else if (s.op == OP_READ) begin
					n.seg_rd = 1'b1; // R13
					n.byten  = 2'h0;
					n.nbytes = 2'h1;
					n.st     = ST_GAP;
				end else begin
					n.done = 1'b1; // R21
					n.st   = ST_STOP_A;
				end
			end
		end
		ST_GAP: begin
			if (s.cnt == CNT_W'(LOW_HALF)) begin
				n.pins.sda_oe = 1'b0;
			end
			if (s.cnt == '0) begin
				n.pins.scl_oe = 1'b0;
				n.st  = ST_START_A;
				n.cnt = CNT_W'(SU_STA_CYC - 1);
			end
		end
		ST_STOP_A: begin
			if (s.cnt == CNT_W'(LOW_HALF)) begin
				n.pins.sda_oe = 1'b1;
			end
			if (s.cnt == '0) begin
				n.pins.scl_oe = 1'b0;
				n.st  = ST_STOP_B;
				n.cnt = CNT_W'(SU_STO_CYC - 1);
			end
		end
		ST_STOP_B: begin
			if (!scl_s) begin
				n.cnt = s.cnt;
			end else if (s.cnt == '0) begin
				n.pins.sda_oe = 1'b0; // R10
				n.st  = ST_STOP_C;
				n.cnt = CNT_W'(BUF_CYC - 1);
			end
		end
		ST_STOP_C: begin
			if (s.cnt == '0) begin
				n.st = ST_IDLE;
			end
		end
		default: begin
			n.st = ST_IDLE;
			n.pins.scl_oe = 1'b0;
			n.pins.sda_oe = 1'b0;
		end
		endcase
		n.pins.scl_out = 1'b0;
		n.pins.sda_out = 1'b0;
	end

	// single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rdata = s.rdata;
	assign pins  = s.pins;

	// run lengths of clock low and released, for checking only
	logic [CNT_W-1:0] low_run;
	logic [CNT_W-1:0] high_run;
	always_ff @(posedge clk) begin
		if (rst) begin
			low_run  <= '0;
			high_run <= '0;
		end else begin
			low_run  <= s.pins.scl_oe && !(&low_run) ? low_run + 1'b1
				: (s.pins.scl_oe ? low_run : '0);
			high_run <= !s.pins.scl_oe && !(&high_run) ? high_run + 1'b1
				: (!s.pins.scl_oe ? high_run : '0);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence ack_miss;
		ack_end && !s.reading && sda_s;
	endsequence
	sequence stop_walk;
		s.st == ST_STOP_A ##[1:400] s.st == ST_STOP_B;
	endsequence

	AST_LOW_TIME: assert property ($fell(s.pins.scl_oe) |-> // R7
		$past(low_run) >= CNT_W'(LOW_CYC - 1))
		else $error("clock low phase too short");
	AST_HIGH_TIME: assert property ($rose(s.pins.scl_oe) |-> // R7
		$past(high_run) >= CNT_W'(HIGH_CYC - 1))
		else $error("clock high phase too short");
	AST_SDA_STABLE: assert property (s.st == ST_HIGH // R9
		&& $past(s.st) == ST_HIGH |-> $stable(s.pins.sda_oe))
		else $error("data moved while clock high");
	AST_START_ONLY: assert property ($rose(s.pins.sda_oe) // R10
		&& !s.pins.scl_oe |-> s.st == ST_START_B)
		else $error("data fell with clock high outside start");
	AST_STOP_ONLY: assert property ($fell(s.pins.sda_oe) // R10
		&& !s.pins.scl_oe |-> s.st == ST_STOP_C)
		else $error("data rose with clock high outside stop");
	AST_BIT_ORDER: assert property (s.st == ST_LOW // R8
		&& $past(s.st) == ST_HIGH |->
		s.bitn == ($past(s.bitn) == 4'h8 ? 4'h0 : $past(s.bitn) + 4'h1))
		else $error("bit counter out of step");
	AST_NACK_STOP: assert property (ack_miss |=> stop_walk) // R16
		else $error("missing acknowledge did not stop");
	AST_HOST_ACK: assert property (s.st == ST_HIGH && s.bitn == 4'h8 // R15
		|-> s.pins.sda_oe == (s.reading && s.byten == 2'h0))
		else $error("wrong level in acknowledge slot");
	AST_RW_BIT: assert property (s.st == ST_LOW && $past(s.st) // R18
		== ST_START_B |-> s.shreg[0] == s.seg_rd)
		else $error("direction bit wrong");
	AST_PAD_ZERO: assert property (s.st == ST_LOW && s.bitn == 4'h0 // R20
		&& s.byten == 2'h2 && s.op == OP_WRITE |-> s.shreg[1:0] == 2'h0)
		else $error("pad bits not zero");
	AST_RSTART: assert property ($rose(s.seg_rd) |-> s.st == ST_GAP // R13
		##[1:400] s.st == ST_START_A)
		else $error("read not led by repeated start");
endmodule

// >>> testbench/dac_dev_model.sv
// behavioural model of the dual converter on the two-wire bus
`timescale 1ns/1ps
module dac_dev_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       add_pin,
	input  wire logic       variant,
	output logic            sda_oe,
	output logic      [9:0] in_a,
	output logic      [9:0] in_b,
	output logic      [9:0] out_a,
	output logic      [9:0] out_b,
	output logic      [1:0] pd_a,
	output logic      [1:0] pd_b
);
	logic [7:0]  sh;
	logic [7:0]  b1;
	logic [15:0] tx;
	logic        act;
	logic        rdm;
	logic        rsel;
	int          bc;
	int          nb;
	// command table for code words
	task automatic ld(input logic [3:0] c, input logic [9:0] v);
		if (c[3:2] == 2'b10) {out_a, out_b} = {in_a, in_b};
		if (c[3:2] == 2'b11) {in_a, in_b} = {v, v};
		else if (c[0]) in_b = v;
		else in_a = v;
		if (c[3:2] == 2'b00 || c == 4'hC) {out_a, out_b} = {in_a, in_b};
	endtask
	// power-on: zero scale, powered down with 100k termination
	initial begin
		{in_a, in_b, out_a, out_b} = '0;
		{pd_a, pd_b} = 4'hF;
		{sda_oe, act, rdm, rsel} = '0;
		{bc, nb} = '0;
	end
	// start restarts framing, stop idles the interface
	always @(negedge sda) if (scl) begin
		{act, rdm, bc, nb} = {1'b1, 1'b0, 64'h0};
	end
	always @(posedge sda) if (scl) begin
		{act, sda_oe} = 2'b00;
	end
	// bits shift in on the rising clock, a master nack ends a read
	always @(posedge scl) if (act) begin
		if (bc < 8) sh = {sh[6:0], sda};
		else if (rdm && sda) act = 1'b0;
		bc++;
	end
	// acknowledge, data out and register updates on the falling clock
	always @(negedge scl) if (act) begin
		if (bc == 9) begin
			bc = 0;
			if (!rdm) sda_oe = 1'b0;
			if (nb == 2 && b1[7:4] == 4'hE) begin
				{out_a, out_b} = {in_a, in_b};
				nb = 1;
			end
			if (nb == 2 && b1[7:2] == 6'h3C) rsel = b1[1];
			if (nb == 3) begin
				nb = 1;
				if (b1 == 8'hF0) begin
					if (sh[4]) pd_a = sh[3:2];
					if (sh[5]) pd_b = sh[3:2];
				end else ld(b1[7:4], {b1[3:0], sh[7:2]});
			end
		end
		if (rdm) begin
			sda_oe = (bc < 8) && !tx[15];
			if (bc < 8) tx = {tx[14:0], 1'b0};
		end else if (bc == 8) begin
			if (nb == 0 && sh[7:1] != {variant ? 6'h2C : 6'h1C, add_pin})
				act = 1'b0;
			else begin
				sda_oe = 1'b1;
				rdm = (nb == 0) && sh[0];
				tx = {4'h0, rsel ? out_b : out_a, 2'b00};
				if (nb == 1) b1 = sh;
				nb++;
			end
		end
	end
endmodule

// >>> testbench/dac_host_ctrl_tb.sv
// self-checking bench for the converter bus controller
`timescale 1ns/1ps
module dac_host_ctrl_tb
	import dac_host_pkg::*;
;
	logic        clk, rst, scl, sda, dev_oe;
	bus_req_t    req;
	logic [31:0] rdata, s, seed;
	pin_out_t    pins;
	logic [9:0]  in_a, in_b, out_a, out_b, v;
	logic [1:0]  pd_a, pd_b;
	logic [3:0]  pdtab [3] = '{4'h5, 4'hA, 4'hC};
	int          failures, checks, cyc, rises, exp_rises, eo, ep [2];
	real         tl = -1.0e6;
	// open-drain lines with pull-ups
	assign scl = !pins.scl_oe;
	assign sda = !(pins.sda_oe || dev_oe);
	dac_host_ctrl dut (.clk(clk), .rst(rst), .req(req), .scl_in(scl),
		.sda_in(sda), .rdata(rdata), .pins(pins));
	dac_dev_model dev (.scl(scl), .sda(sda), .add_pin(1'b0),
		.variant(1'b1), .sda_oe(dev_oe), .in_a(in_a), .in_b(in_b),
		.out_a(out_a), .out_b(out_b), .pd_a(pd_a), .pd_b(pd_b));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// start an operation and wait for busy to drop
	task run(input logic [31:0] g, input int r);
		exp_rises = r;
		reg_wr(REG_GO, g);
		for (int i = 0; i < 40000; i++) begin
			reg_rd(REG_STATUS, s);
			if (s[ST_BUSY_BIT] === 1'b0) break;
		end
	endtask
	task check_dev;
		chk(32'(out_a), eo);
		chk(32'(out_b), eo);
		chk(32'(pd_a), ep[0]);
		chk(32'(pd_b), ep[1]);
		chk(32'({pins.scl_out, pins.sda_out}), 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 150000) begin
			failures++;
			conclude();
		end
	end
	// wire watch: pulses per frame and clock rate
	always @(posedge scl) if (!rst) begin
		rises++;
		chk(32'($realtime - tl >= 2499.0), 32'h1);
		tl = $realtime;
	end
	always @(posedge sda) if (scl && !rst) begin
		chk(32'(rises), 32'(exp_rises));
		rises = 0;
	end
	initial begin
		req = '0;
		rst = 1'b1;
		{failures, checks, cyc, rises, eo} = '0;
		ep = '{3, 3};
		seed = xs(32'h54EB);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		check_dev();
		reg_rd(8'h20, s);
		chk(s, 32'h0);
		// wrong address low bit: device stays silent
		reg_wr(REG_CFG, 32'h3);
		run({30'h0, OP_WRITE}, 10);
		reg_rd(REG_STATUS, s);
		chk(s, 32'h2);
		reg_wr(REG_STATUS, 32'h6);
		reg_rd(REG_STATUS, s);
		chk(s, 32'h0);
		// load both channels and outputs with a random code
		reg_wr(REG_CFG, 32'h2);
		v = seed[9:0];
		reg_wr(REG_CODE, 32'({4'hC, v}));
		run({30'h0, OP_WRITE}, 28);
		eo = 32'(v);
		ep = '{0, 0};
		ep = '{3, 3};
		reg_rd(REG_STATUS, s);
		chk(s, 32'h4);
		check_dev();
		// power-down modes on chosen channels, then wake both
		for (int i = 0; i < 3; i++) begin
			reg_wr(REG_STATUS, 32'h6);
			reg_wr(REG_PD, 32'(pdtab[i]));
			run({30'h0, OP_POWER}, 28);
			if (pdtab[i][2]) ep[0] = 32'(pdtab[i][1:0]);
			if (pdtab[i][3]) ep[1] = 32'(pdtab[i][1:0]);
			check_dev();
		end
		// read back channel B over a repeated start
		run({29'h0, 1'b1, OP_READ}, 47);
		reg_rd(REG_RDATA, s);
		chk(s, 32'({v, 2'b00}));
		reg_rd(REG_STATUS, s);
		chk(s, 32'h4);
		conclude();
	end
endmodule
